// ===== rtl/report_pkg.sv
package report_pkg;

    // report codes
    localparam logic [7:0] CODE_COMPLETE = 8'h60;
    localparam logic [7:0] CODE_REJECTED = 8'h64;
    localparam logic [7:0] CODE_INVALID = 8'h65;
    localparam logic [7:0] CODE_REG_PARITY = 8'h66;
    localparam logic [7:0] CODE_PAUSE = 8'h67;
    localparam logic [7:0] CODE_DIAG_GOOD = 8'h68;
    localparam logic [7:0] CODE_DIAG_BAD = 8'h69;
    localparam logic [7:0] CODE_DISCONNECT = 8'h70;
    localparam logic [7:0] CODE_XFER_DISC = 8'h31;
    localparam logic [7:0] CODE_NONE = 8'h00;

    localparam logic [7:0] MSG_LIMIT = 8'h21;
    localparam logic [7:0] MSG_STORED_MIN = 8'h02;

    // register map, byte addresses
    localparam logic [3:0] ADDR_CODE = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_CONTROL = 4'h8;
    localparam logic [3:0] ADDR_COMMAND = 4'hC;
    localparam logic [31:0] RESET_CONTROL = 32'h0000_0000;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        ROLE_ANY,
        ROLE_INITIATOR,
        ROLE_TARGET
    } cmd_role_t;

    // decoded features of a command written by the host
    typedef struct packed {
        cmd_role_t role;
        logic starts_transfer;
        logic starts_select;
        logic needs_count;
        logic is_send_message;
        logic is_pause;
        logic is_diag;
        logic uses_cdb67;
        logic group34_or_xfer;
    } cmd_info_t;

    // status of the rest of the controller
    typedef struct packed {
        logic is_initiator;
        logic is_target;
        logic nexus;
        logic auto_response;
        logic busy;
        logic transferring;
        logic seq_in_memory;
        logic count_zero;
        logic cdb67_len_zero;
        logic [7:0] send_message_len;
    } ctl_state_t;

    typedef struct packed {
        logic cmd_done;
        logic diag_done;
        logic diag_fault;
        logic bus_free;
        logic msg_byte;
        logic [7:0] msg_len;
    } ctl_event_t;

endpackage : report_pkg

// ===== rtl/command_decode.sv
`timescale 1ns/1ns
module command_decode
    import report_pkg::*;
(
    // opcode
    input wire logic [7:0] opcode,
    // decoded
    output cmd_info_t info
);
    // opcode classes: bits 7:6 role, 5:4 start, 3:0 kind
    always_comb begin
        info = '0;
        unique case (opcode[7:6])
            2'h1: info.role = ROLE_INITIATOR;
            2'h2: info.role = ROLE_TARGET;
            default: info.role = ROLE_ANY;
        endcase
        info.starts_transfer = (opcode[5:4] == 2'h1);
        info.starts_select = (opcode[5:4] == 2'h2);
        info.needs_count = (opcode[5:4] == 2'h3);
        info.is_send_message = (opcode[3:0] == 4'h1);
        info.is_pause = (opcode[3:0] == 4'h2);
        info.is_diag = (opcode[3:0] == 4'h3);
        info.uses_cdb67 = (opcode[3:0] == 4'h4);
        info.group34_or_xfer = (opcode[3:0] == 4'h5);
    end
endmodule : command_decode

// ===== rtl/parity_check.sv
`timescale 1ns/1ns
module parity_check (
    // written byte with its odd parity bit
    input wire logic [7:0] data,
    input wire logic par,
    // result
    output logic error
);
    assign error = ~(^{data, par});
endmodule : parity_check

// ===== rtl/command_report_code_gen.sv
// Chosen here: register access over AXI4-Lite and the address map.
`timescale 1ns/1ns
module command_report_code_gen
    import report_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // controller state and events
    input ctl_state_t state,
    input ctl_event_t event_in,
    // command handed to the sequencer
    output logic cmd_start,
    output logic [7:0] cmd_opcode,
    // report
    output logic irq,
    output logic [7:0] report_code
);
    logic aw_held;
    logic w_held;
    logic [3:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [31:0] control;
    logic cmd_valid;
    logic [7:0] cmd_byte;
    logic cmd_parity_err;
    logic [7:0] next_code;
    logic pending;
    logic msg_paused;
    logic [1:0] msg_seen;
    logic pause_wait;
    cmd_info_t info;
    logic write_fire;
    logic read_fire;
    logic read_clear;

    assign write_fire = aw_held && w_held && !s_axi_bvalid;

    command_decode u_decode (
        .opcode(cmd_byte),
        .info(info)
    );

    // byte-lane-0 parity bit in wdata[8]
    parity_check u_parity (
        .data(w_data[7:0]),
        .par(w_data[8]),
        .error(cmd_parity_err)
    );

    // write address and data accepted independently
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= 4'h0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr[3:0];
        end else if (write_fire) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (write_fire) begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (write_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr == ADDR_CONTROL || aw_addr == ADDR_COMMAND)
                ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // control: bit 0 enables parity checking of host writes to the control and command registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            control <= RESET_CONTROL;
        end else if (write_fire && aw_addr == ADDR_CONTROL && w_strb[0]) begin
            control <= {24'h00_0000, w_data[7:0]};
        end
    end

    // command register: one cycle later the checks run on the latched byte
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmd_valid <= 1'b0;
            cmd_byte <= 8'h00;
        end else if (write_fire && aw_addr == ADDR_COMMAND && w_strb[0]) begin
            cmd_valid <= 1'b1;
            cmd_byte <= w_data[7:0];
        end else begin
            cmd_valid <= 1'b0;
        end
    end

    logic parity_hit;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            parity_hit <= 1'b0;
        end else begin
            parity_hit <= write_fire && w_strb[0] && control[0] && cmd_parity_err
                && (aw_addr == ADDR_COMMAND || aw_addr == ADDR_CONTROL);
        end
    end

    // priority: parity, reject, invalid, then the command's own effect
    logic accept;
    always_comb begin
        next_code = CODE_NONE;
        accept = 1'b0;
        if (parity_hit) begin
            next_code = CODE_REG_PARITY;
        end else if (cmd_valid) begin
            if (state.auto_response) begin
                next_code = CODE_REJECTED;
            end else if (state.busy) begin
                next_code = CODE_REJECTED;
            end else if (info.is_send_message && state.send_message_len >= MSG_LIMIT) begin
                next_code = CODE_REJECTED;
            end else if ((info.role == ROLE_TARGET && state.is_initiator)
                || (info.role == ROLE_INITIATOR && state.is_target)) begin
                next_code = CODE_INVALID;
            end else if (state.seq_in_memory) begin
                next_code = CODE_INVALID;
            end else if (info.needs_count && state.count_zero) begin
                next_code = CODE_INVALID;
            end else if (info.uses_cdb67 && state.cdb67_len_zero) begin
                next_code = CODE_INVALID;
            end else if (info.group34_or_xfer) begin
                next_code = CODE_INVALID;
            end else if (info.starts_transfer && !state.nexus) begin
                next_code = CODE_INVALID;
            end else if (info.starts_select && state.nexus) begin
                next_code = CODE_INVALID;
            end else begin
                accept = 1'b1;
            end
        end else if (event_in.diag_done) begin
            next_code = event_in.diag_fault ? CODE_DIAG_BAD : CODE_DIAG_GOOD;
        end else if (event_in.cmd_done) begin
            next_code = pause_wait ? CODE_PAUSE : CODE_COMPLETE;
        end else if (event_in.bus_free && state.transferring) begin
            next_code = CODE_XFER_DISC;
        end else if (event_in.bus_free && state.is_initiator) begin
            next_code = CODE_DISCONNECT;
        end else if (event_in.msg_byte && !msg_paused && event_in.msg_len >= MSG_LIMIT
            && ({6'h00, msg_seen} + 8'h01) >= MSG_STORED_MIN) begin
            next_code = CODE_PAUSE;
        end
    end

    // pause command remembered until its completion event
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pause_wait <= 1'b0;
        end else if (accept) begin
            pause_wait <= info.is_pause;
        end else if (event_in.cmd_done && !cmd_valid && !parity_hit) begin
            pause_wait <= 1'b0;
        end
    end

    // one pause per long message; msg_len is the length the message declares
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            msg_paused <= 1'b0;
        end else if (next_code == CODE_PAUSE && !event_in.cmd_done) begin
            msg_paused <= 1'b1;
        end else if (!event_in.msg_byte && event_in.msg_len == 8'h00) begin
            msg_paused <= 1'b0;
        end
    end

    // bytes stored of the current message; the length byte is the second
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            msg_seen <= 2'h0;
        end else if (!event_in.msg_byte && event_in.msg_len == 8'h00) begin
            msg_seen <= 2'h0;
        end else if (event_in.msg_byte && msg_seen != 2'h3) begin
            msg_seen <= msg_seen + 2'h1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmd_start <= 1'b0;
            cmd_opcode <= 8'h00;
        end else begin
            cmd_start <= accept;
            cmd_opcode <= accept ? cmd_byte : cmd_opcode;
        end
    end

    // reading the code register clears pending and irq but keeps the code; a new code in that cycle wins
    assign read_fire = s_axi_arvalid && s_axi_arready;
    assign read_clear = read_fire && s_axi_araddr[3:0] == ADDR_CODE;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            report_code <= CODE_NONE;
            pending <= 1'b0;
            irq <= 1'b0;
        end else if (next_code != CODE_NONE) begin
            report_code <= next_code;
            pending <= 1'b1;
            irq <= 1'b1;
        end else if (read_clear) begin
            pending <= 1'b0;
            irq <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (read_fire) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            unique case (s_axi_araddr[3:0])
                ADDR_CODE: s_axi_rdata <= {24'h00_0000, report_code};
                ADDR_STATUS: s_axi_rdata <= {29'h0000_0000, pause_wait, state.busy, pending};
                ADDR_CONTROL: s_axi_rdata <= control;
                ADDR_COMMAND: s_axi_rdata <= {24'h00_0000, cmd_opcode};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end else begin
            s_axi_arready <= 1'b1;
        end
    end
endmodule : command_report_code_gen

// ===== bench/report_props.sv
`timescale 1ns/1ns
module report_props
    import report_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // watched
    input wire logic s_axi_bvalid,
    input wire ctl_state_t state,
    input wire ctl_event_t event_in,
    input wire logic cmd_start,
    input wire logic [7:0] cmd_opcode,
    input wire logic irq,
    input wire logic [7:0] report_code
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // a command report lands the edge after bvalid, so events then are left out
    sequence s_code(logic [7:0] c);
        ##1 report_code == c && irq;
    endsequence
    AST_DIAG_GOOD: assert property (event_in.diag_done && !event_in.diag_fault && !s_axi_bvalid
        |-> s_code(CODE_DIAG_GOOD)) else $error("diag good code missing");
    AST_DIAG_BAD: assert property (event_in.diag_done && event_in.diag_fault && !s_axi_bvalid
        |-> s_code(CODE_DIAG_BAD)) else $error("diag fault code missing");
    AST_XFER_DISC: assert property (event_in.bus_free && state.transferring && !s_axi_bvalid
        && !event_in.diag_done && !event_in.cmd_done |-> s_code(CODE_XFER_DISC))
        else $error("transfer disconnect code missing");
    AST_IDLE_DISC: assert property (event_in.bus_free && !state.transferring
        && state.is_initiator && !s_axi_bvalid && !event_in.diag_done && !event_in.cmd_done
        |-> s_code(CODE_DISCONNECT)) else $error("idle disconnect code missing");
    AST_NEW_CODE_IRQ: assert property ($changed(report_code) |-> irq)
        else $error("new code without irq");
    AST_START_FREE: assert property (cmd_start |-> !$past(state.auto_response)
        && !$past(state.busy)) else $error("command started while engaged");
    AST_MSG_LEN: assert property (cmd_start && cmd_opcode[3:0] == 4'h1
        |-> $past(state.send_message_len) < MSG_LIMIT) else $error("long message started");
    AST_ROLE: assert property (cmd_start && cmd_opcode[7:6] == 2'h1 |-> !$past(state.is_target))
        else $error("initiator command started as target");
    AST_NEXUS: assert property (cmd_start |-> !(cmd_opcode[5:4] == 2'h1 && !$past(state.nexus))
        && !(cmd_opcode[5:4] == 2'h2 && $past(state.nexus))) else $error("nexus check broken");
endmodule : report_props

// ===== bench/host_model.sv
`timescale 1ns/1ns
module host_model (
    // clock
    input wire logic aclk,
    // write
    output logic [31:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    // read
    output logic [31:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready
);
    logic hung = 1'b0;
    initial {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;
    task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        {awaddr, wdata, wstrb} <= {a, d, 4'hF};
        {awvalid, wvalid, bready} <= 3'h7;
        // each channel dropped only at the edge that takes it
        do begin
            @(posedge aclk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid && n < 40);
        hung = hung | !bvalid;
        r = bresp;
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        do begin
            @(posedge aclk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (!rvalid && n < 40);
        hung = hung | !rvalid;
        {d, r} = {rdata, rresp};
        rready <= 1'b0;
    endtask : rd
endmodule : host_model

// ===== bench/tb.sv
`timescale 1ns/1ns
module tb
    import report_pkg::*;
;
    // flags: initiator,target,nexus,auto,busy,xfer,seq,count0,cdb0 then send length
    localparam ctl_state_t idle_init = {9'h100, 8'h00};
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [31:0] awaddr, wdata, araddr, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic awvalid, awready, wvalid, wready, bvalid, bready, cmd_start, irq;
    logic arvalid, arready, rvalid, rready;
    logic [7:0] cmd_opcode, report_code;
    ctl_state_t state = '0;
    ctl_event_t event_in = '0;
    int num_errors = 0;
    int n_checks = 0;
    always #50 aclk = ~aclk;
    command_report_code_gen i_dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .state(state), .event_in(event_in), .cmd_start(cmd_start), .cmd_opcode(cmd_opcode),
        .irq(irq), .report_code(report_code));
    host_model i_host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : give_verdict
    always @(posedge i_host.hung) begin
        num_errors++;
        give_verdict();
    end
    task automatic chk(input logic ok, input string m);
        n_checks++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask : chk
    task automatic st(input ctl_state_t s);
        @(posedge aclk);
        state <= s;
    endtask : st
    task automatic clr(input logic [7:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        i_host.rd({28'h0, ADDR_CODE}, d, r);
        chk(d[7:0] === exp && r === RESP_OKAY, "code read back");
        @(posedge aclk);
        #1;
        chk(irq === 1'b0, "irq still high after read");
    endtask : clr
    task automatic ev(input ctl_event_t e, input logic [7:0] exp);
        @(posedge aclk);
        event_in <= e;
        @(posedge aclk);
        // the declared message length stands between bytes
        event_in <= {5'h00, e.msg_len};
        #1;
        if (exp == CODE_NONE) begin
            chk(irq === 1'b0, "unexpected report");
        end else begin
            chk(report_code === exp && irq === 1'b1, "event report wrong");
            clr(exp);
        end
    endtask : ev
    task automatic cmd(input ctl_state_t s, input logic [7:0] op, input logic bad,
        input logic [7:0] exp);
        logic [1:0] r;
        st(s);
        i_host.wr({28'h0, ADDR_COMMAND}, {23'h0, ~^op ^ bad, op}, r);
        #1;
        for (int i = 0; i < 4 && cmd_start !== 1'b1 && irq !== 1'b1; i++) begin
            @(posedge aclk);
            #1;
        end
        chk(r === RESP_OKAY, "command write response");
        if (exp == CODE_NONE) begin
            chk(cmd_start === 1'b1 && cmd_opcode === op && irq === 1'b0, "command not started");
            ev({5'h10, 8'h00}, op[3:0] == 4'h2 ? CODE_PAUSE : CODE_COMPLETE);
        end else begin
            chk(report_code === exp && irq === 1'b1 && cmd_start === 1'b0, "command report");
            clr(exp);
        end
    endtask : cmd
    task automatic t_regs;
        logic [31:0] d;
        logic [1:0] r;
        i_host.rd({28'h0, ADDR_CONTROL}, d, r);
        chk(d === RESET_CONTROL && r === RESP_OKAY, "control reset value");
        // only the low four address bits are decoded
        i_host.rd(32'h0000_0006, d, r);
        chk(r === RESP_SLVERR, "unmapped read accepted");
        i_host.wr({28'h0, ADDR_CODE}, 32'h0000_0060, r);
        chk(r === RESP_SLVERR && irq === 1'b0, "code register written");
        $display("regs test done");
    endtask : t_regs
    task automatic t_commands;
        cmd({9'h120, 8'h00}, 8'h00, 1'b0, CODE_REJECTED);
        cmd({9'h110, 8'h00}, 8'h00, 1'b0, CODE_REJECTED);
        cmd({9'h100, 8'h21}, 8'h01, 1'b0, CODE_REJECTED);
        cmd({9'h100, 8'h20}, 8'h01, 1'b0, CODE_NONE);
        cmd({9'h080, 8'h00}, 8'h40, 1'b0, CODE_INVALID);
        cmd(idle_init, 8'h80, 1'b0, CODE_INVALID);
        cmd({9'h104, 8'h00}, 8'h00, 1'b0, CODE_INVALID);
        cmd({9'h102, 8'h00}, 8'h30, 1'b0, CODE_INVALID);
        cmd({9'h101, 8'h00}, 8'h04, 1'b0, CODE_INVALID);
        cmd(idle_init, 8'h05, 1'b0, CODE_INVALID);
        cmd(idle_init, 8'h10, 1'b0, CODE_INVALID);
        cmd({9'h140, 8'h00}, 8'h20, 1'b0, CODE_INVALID);
        cmd({9'h140, 8'h00}, 8'h50, 1'b0, CODE_NONE);
        cmd(idle_init, 8'h22, 1'b0, CODE_NONE);
        $display("command test done");
    endtask : t_commands
    task automatic t_parity;
        logic [31:0] d;
        logic [1:0] r;
        i_host.wr({28'h0, ADDR_CONTROL}, 32'h0000_0001, r);
        i_host.wr({28'h0, ADDR_CONTROL}, 32'h0000_0101, r);
        #1;
        chk(report_code === CODE_REG_PARITY && irq === 1'b1, "control parity missed");
        clr(CODE_REG_PARITY);
        cmd(idle_init, 8'h00, 1'b1, CODE_REG_PARITY);
        cmd(idle_init, 8'h40, 1'b0, CODE_NONE);
        i_host.rd({28'h0, ADDR_COMMAND}, d, r);
        chk(d === 32'h0000_0040 && r === RESP_OKAY, "command read back");
        // parity bit set so that disabling the check is not itself flagged
        i_host.wr({28'h0, ADDR_CONTROL}, 32'h0000_0100, r);
        #1;
        chk(irq === 1'b0, "clean control write flagged");
        $display("parity test done");
    endtask : t_parity
    task automatic t_events;
        st(idle_init);
        ev({5'h08, 8'h00}, CODE_DIAG_GOOD);
        ev({5'h0C, 8'h00}, CODE_DIAG_BAD);
        st({9'h148, 8'h00});
        ev({5'h02, 8'h00}, CODE_XFER_DISC);
        st({9'h140, 8'h00});
        ev({5'h02, 8'h00}, CODE_DISCONNECT);
        ev({5'h01, 8'h20}, CODE_NONE);
        ev({5'h01, 8'h20}, CODE_NONE);
        ev('0, CODE_NONE);
        ev({5'h01, 8'h21}, CODE_NONE);
        ev({5'h01, 8'h21}, CODE_PAUSE);
        ev({5'h01, 8'h21}, CODE_NONE);
        $display("event test done");
    endtask : t_events
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        t_regs();
        t_commands();
        t_parity();
        t_events();
        give_verdict();
    end
endmodule : tb
bind command_report_code_gen report_props i_props (.aclk(aclk), .aresetn(aresetn),
    .s_axi_bvalid(s_axi_bvalid), .state(state), .event_in(event_in), .cmd_start(cmd_start),
    .cmd_opcode(cmd_opcode), .irq(irq), .report_code(report_code));
